/* File: verilog/jrx_link_config_regs.v */
`timescale 1ns/10ps
`include "jrx_defs.vh"
module jrx_link_config_regs
#(
  parameter LANE_W = 32
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // AHB-Lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg hreadyout_o,
  output reg hresp_o,
  output reg [31:0] hrdata_o,
  // Termination calibration
  input wire [`JRX_CAL_W-1:0] cal_code5_i,
  input wire [`JRX_CAL_W-1:0] cal_code6_i,
  input wire [`JRX_CAL_W-1:0] cal_code7_i,
  output wire [`JRX_CAL_W-1:0] term_code5_o,
  output wire [`JRX_CAL_W-1:0] term_code6_o,
  output wire [`JRX_CAL_W-1:0] term_code7_o,
  // Link parameters
  input wire [`JRX_CFG_OCTETS*`JRX_OCTET_W-1:0] cfg_octets_i,
  output reg [`JRX_OCTET_W-1:0] checksum_o,
  output reg link_enable_o,
  // Multiframe timing
  input wire pclk_en_i,
  input wire frame_en_i,
  input wire global_lmfc_i,
  input wire local_lmfc_i,
  output reg global_lmfc_dly_o,
  output reg buffer_release_o,
  // Lane crossbar
  input wire [8*LANE_W-1:0] serial_lanes_i,
  output reg [LANE_W-1:0] logical_lane0_o,
  output reg [LANE_W-1:0] logical_lane1_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [`JRX_TRIM_W-1:0] lane5_termination_trim;
  reg [`JRX_TRIM_W-1:0] lane6_termination_trim;
  reg [`JRX_TRIM_W-1:0] lane7_termination_trim;
  reg checksum_mode;
  reg [`JRX_DLY_W-1:0] measured_link_latency;
  reg [`JRX_DLY_W-1:0] multiframe_fixed_delay;
  reg [`JRX_DLY_W-1:0] multiframe_release_point;
  reg [`JRX_SRC_W-1:0] logical_lane0_source;
  reg [`JRX_SRC_W-1:0] logical_lane1_source;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave
  // Reads take one wait state so a write just before is always seen
  reg wr_pend;
  reg rd_pend;
  reg [`JRX_IDX_W-1:0] ph_idx;
  reg ph_hit;
  reg [31:0] rd_mux;

  wire addr_phase = hsel_i & htrans_i[1] & hready_i;
  wire addr_hit = (haddr_i[31:`JRX_IDX_W+2] == {(30-`JRX_IDX_W){1'b0}});

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      ph_idx <= {`JRX_IDX_W{1'b0}};
      ph_hit <= 1'b0;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h0000_0000;
    end
    else
    begin
      wr_pend <= 1'b0;
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        hrdata_o <= rd_mux;
        hreadyout_o <= 1'b1;
      end
      else if (addr_phase)
      begin
        ph_idx <= haddr_i[`JRX_IDX_W+1:2];
        ph_hit <= addr_hit;
        wr_pend <= hwrite_i;
        rd_pend <= ~hwrite_i;
        hreadyout_o <= hwrite_i;
      end
    end
  end

  // Unmapped and reserved bits read zero
  always @*
  begin
    rd_mux = 32'h0000_0000;
    if (ph_hit)
    begin
      case (ph_idx)
        `JRX_IDX_TRIM5: rd_mux[`JRX_TRIM_W-1:0] = lane5_termination_trim;
        `JRX_IDX_TRIM6: rd_mux[`JRX_TRIM_W-1:0] = lane6_termination_trim;
        `JRX_IDX_TRIM7: rd_mux[`JRX_TRIM_W-1:0] = lane7_termination_trim;
        `JRX_IDX_GENCTL:
        begin
          rd_mux[`JRX_CKSUM_BIT] = checksum_mode;
          rd_mux[`JRX_LINKEN_BIT] = link_enable_o;
        end
        `JRX_IDX_LATENCY: rd_mux[`JRX_DLY_W-1:0] = measured_link_latency;
        `JRX_IDX_FIXDLY: rd_mux[`JRX_DLY_W-1:0] = multiframe_fixed_delay;
        `JRX_IDX_RELPT: rd_mux[`JRX_DLY_W-1:0] = multiframe_release_point;
        `JRX_IDX_XBAR01:
        begin
          rd_mux[`JRX_SRC1_LO+`JRX_SRC_W-1:`JRX_SRC1_LO] = logical_lane1_source;
          rd_mux[`JRX_SRC0_LO+`JRX_SRC_W-1:`JRX_SRC0_LO] = logical_lane0_source;
        end
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Writes keep only defined fields
  wire wr_en = wr_pend & ph_hit;
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lane5_termination_trim <= `JRX_TRIM_RST;
      lane6_termination_trim <= `JRX_TRIM_RST;
      lane7_termination_trim <= `JRX_TRIM_RST;
      checksum_mode <= 1'b0;
      link_enable_o <= 1'b0;
      multiframe_fixed_delay <= `JRX_FIXDLY_RST;
      multiframe_release_point <= `JRX_RELPT_RST;
      logical_lane0_source <= `JRX_SRC0_RST;
      logical_lane1_source <= `JRX_SRC1_RST;
    end
    else if (wr_en)
    begin
      case (ph_idx)
        `JRX_IDX_TRIM5: lane5_termination_trim <= hwdata_i[`JRX_TRIM_W-1:0];
        `JRX_IDX_TRIM6: lane6_termination_trim <= hwdata_i[`JRX_TRIM_W-1:0];
        `JRX_IDX_TRIM7: lane7_termination_trim <= hwdata_i[`JRX_TRIM_W-1:0];
        `JRX_IDX_GENCTL:
        begin
          checksum_mode <= hwdata_i[`JRX_CKSUM_BIT];
          link_enable_o <= hwdata_i[`JRX_LINKEN_BIT];
        end
        `JRX_IDX_FIXDLY: multiframe_fixed_delay <= hwdata_i[`JRX_DLY_W-1:0];
        // No clamp at ten: keeping it in range is up to software
        `JRX_IDX_RELPT: multiframe_release_point <= hwdata_i[`JRX_DLY_W-1:0];
        `JRX_IDX_XBAR01:
        begin
          logical_lane1_source <= hwdata_i[`JRX_SRC1_LO+`JRX_SRC_W-1:`JRX_SRC1_LO];
          logical_lane0_source <= hwdata_i[`JRX_SRC0_LO+`JRX_SRC_W-1:`JRX_SRC0_LO];
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination trim per lane
  jrx_trim_lane u_trim5
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cal_code_i(cal_code5_i),
    .trim_i(lane5_termination_trim),
    .term_code_o(term_code5_o)
  );

  jrx_trim_lane u_trim6
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cal_code_i(cal_code6_i),
    .trim_i(lane6_termination_trim),
    .term_code_o(term_code6_o)
  );

  jrx_trim_lane u_trim7
  (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .cal_code_i(cal_code7_i),
    .trim_i(lane7_termination_trim),
    .term_code_o(term_code7_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Link parameter checksum, all sums modulo 256
  reg [`JRX_OCTET_W-1:0] next_checksum;
  reg [`JRX_OCTET_W-1:0] oct [0:`JRX_CFG_OCTETS-1];
  integer i;

  always @*
  begin
    for (i = 0; i < `JRX_CFG_OCTETS; i = i + 1)
      oct[i] = cfg_octets_i[i*`JRX_OCTET_W +: `JRX_OCTET_W];
    next_checksum = 8'h00;
    if (checksum_mode)
    begin
      for (i = 0; i < `JRX_CFG_OCTETS; i = i + 1)
        next_checksum = next_checksum + oct[i];
    end
    else
    begin
      // Field sum as laid out in the standard configuration octets
      next_checksum = oct[0] + {4'h0, oct[1][3:0]} + {4'h0, oct[1][7:4]}
        + {3'h0, oct[2][4:0]} + {7'h00, oct[3][7]} + {3'h0, oct[3][4:0]}
        + oct[4] + {3'h0, oct[5][4:0]} + oct[6] + {6'h00, oct[7][7:6]}
        + {3'h0, oct[7][4:0]} + {5'h00, oct[8][7:5]} + {3'h0, oct[8][4:0]}
        + {5'h00, oct[9][7:5]} + {3'h0, oct[9][4:0]} + {7'h00, oct[10][7]}
        + {3'h0, oct[10][4:0]};
    end
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      checksum_o <= 8'h00;
    else
      checksum_o <= next_checksum;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Multiframe timing
  reg [`JRX_DLY_W-1:0] lat_cnt;
  reg lat_run;
  reg [`JRX_DLY_W-1:0] dly_cnt;
  reg dly_run;
  reg [`JRX_DLY_W-1:0] mf_pos;
  wire [`JRX_DLY_W-1:0] cnt_max = {`JRX_DLY_W{1'b1}};

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      lat_cnt <= {`JRX_DLY_W{1'b0}};
      lat_run <= 1'b0;
      measured_link_latency <= {`JRX_DLY_W{1'b0}};
      dly_cnt <= {`JRX_DLY_W{1'b0}};
      dly_run <= 1'b0;
      global_lmfc_dly_o <= 1'b0;
      mf_pos <= {`JRX_DLY_W{1'b0}};
      buffer_release_o <= 1'b0;
    end
    else
    begin
      // Latency saturates rather than wrapping on a lost boundary
      if (global_lmfc_i && local_lmfc_i)
      begin
        measured_link_latency <= {`JRX_DLY_W{1'b0}};
        lat_run <= 1'b0;
      end
      else if (global_lmfc_i)
      begin
        lat_cnt <= {`JRX_DLY_W{1'b0}};
        lat_run <= 1'b1;
      end
      else if (lat_run && local_lmfc_i)
      begin
        // The local boundary cycle itself still counts as one period
        if (pclk_en_i && lat_cnt != cnt_max)
          measured_link_latency <= lat_cnt + 5'h01;
        else
          measured_link_latency <= lat_cnt;
        lat_run <= 1'b0;
      end
      else if (lat_run && pclk_en_i && lat_cnt != cnt_max)
        lat_cnt <= lat_cnt + 5'h01;
      // Fixed delay of the global boundary in frame clocks
      global_lmfc_dly_o <= 1'b0;
      if (global_lmfc_i)
      begin
        if (multiframe_fixed_delay == {`JRX_DLY_W{1'b0}})
        begin
          // Drop an older countdown so it cannot pulse later
          dly_run <= 1'b0;
          global_lmfc_dly_o <= 1'b1;
        end
        else
        begin
          dly_cnt <= multiframe_fixed_delay;
          dly_run <= 1'b1;
        end
      end
      else if (dly_run && frame_en_i)
      begin
        dly_cnt <= dly_cnt - 5'h01;
        if (dly_cnt == 5'h01)
        begin
          dly_run <= 1'b0;
          global_lmfc_dly_o <= 1'b1;
        end
      end
      // Release buffered words at the chosen multiframe position
      if (local_lmfc_i)
        mf_pos <= {`JRX_DLY_W{1'b0}};
      else if (pclk_en_i && mf_pos != cnt_max)
        mf_pos <= mf_pos + 5'h01;
      buffer_release_o <= link_enable_o & pclk_en_i
        & (mf_pos == multiframe_release_point);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lane crossbar
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      logical_lane0_o <= {LANE_W{1'b0}};
      logical_lane1_o <= {LANE_W{1'b0}};
    end
    else
    begin
      logical_lane0_o <= serial_lanes_i[logical_lane0_source*LANE_W +: LANE_W];
      logical_lane1_o <= serial_lanes_i[logical_lane1_source*LANE_W +: LANE_W];
    end
  end

endmodule

/* File: common/jrx_defs.vh */
`ifndef JRX_DEFS_VH
`define JRX_DEFS_VH

// Register indices (byte address is four times the index)
`define JRX_IDX_W 10
`define JRX_IDX_TRIM5 10'h2c0
`define JRX_IDX_TRIM6 10'h2c1
`define JRX_IDX_TRIM7 10'h2c2
`define JRX_IDX_GENCTL 10'h300
`define JRX_IDX_LATENCY 10'h302
`define JRX_IDX_FIXDLY 10'h304
`define JRX_IDX_RELPT 10'h306
`define JRX_IDX_XBAR01 10'h308

// Field layout
`define JRX_TRIM_W 4
`define JRX_TRIM_SIGN 3
`define JRX_TRIM_MAG_HI 2
`define JRX_CAL_W 4
`define JRX_CKSUM_BIT 6
`define JRX_LINKEN_BIT 0
`define JRX_DLY_W 5
`define JRX_SRC_W 3
`define JRX_SRC1_LO 3
`define JRX_SRC0_LO 0

// Reset values
`define JRX_TRIM_RST 4'h0
`define JRX_FIXDLY_RST 5'h00
`define JRX_RELPT_RST 5'h1f
`define JRX_SRC0_RST 3'h0
`define JRX_SRC1_RST 3'h1

// Checksum
`define JRX_CFG_OCTETS 11
`define JRX_OCTET_W 8

`endif

/* File: verilog/jrx_trim_lane.v */
`timescale 1ns/10ps
`include "jrx_defs.vh"
module jrx_trim_lane
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Codes
  input wire [`JRX_CAL_W-1:0] cal_code_i,
  input wire [`JRX_TRIM_W-1:0] trim_i,
  output reg [`JRX_CAL_W-1:0] term_code_o
);

  localparam [`JRX_CAL_W:0] CODE_MAX = {1'b0, {`JRX_CAL_W{1'b1}}};

  wire [`JRX_CAL_W:0] cal_ext = {1'b0, cal_code_i};
  wire [`JRX_CAL_W:0] mag_ext = {2'h0, trim_i[`JRX_TRIM_MAG_HI:0]};
  wire [`JRX_CAL_W:0] sum = cal_ext + mag_ext;
  reg [`JRX_CAL_W-1:0] next_term;

  // Saturate so a large trim never wraps the code
  always @*
  begin
    next_term = cal_code_i;
    if (trim_i[`JRX_TRIM_SIGN])
    begin
      if (mag_ext > cal_ext)
        next_term = {`JRX_CAL_W{1'b0}};
      else
        next_term = cal_code_i - trim_i[`JRX_TRIM_MAG_HI:0];
    end
    else if (sum > CODE_MAX)
      next_term = {`JRX_CAL_W{1'b1}};
    else
      next_term = sum[`JRX_CAL_W-1:0];
  end

  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      term_code_o <= {`JRX_CAL_W{1'b0}};
    else
      term_code_o <= next_term;
  end

endmodule

/* File: bench/jrx_tx_model.sv */
`timescale 1ns/10ps
module jrx_tx_model
#(
  parameter LANE_W = 32
)
(
  // Clock and reset
  input wire clk_i,
  input wire rst_n_i,
  // Lanes and link timing
  output logic [8*LANE_W-1:0] lanes_o,
  output wire [87:0] cfg_o,
  output logic gmf_o,
  output logic lmf_o
);
  logic [23:0] cnt;
  integer n;
  // Packed fields, so octet sum and field sum differ
  assign cfg_o = {48'h0, 8'h05, 8'h83, 8'h00, 8'h21, 8'h00};
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt <= 24'h0;
    else
      cnt <= cnt + 24'h1;
  end
  // Local boundary trails the global one by six cycles
  always @*
  begin
    gmf_o = (cnt[4:0] == 5'h00);
    lmf_o = (cnt[4:0] == 5'h06);
    // Every lane word changes each cycle
    for (n = 0; n < 8; n = n + 1)
      lanes_o[n*LANE_W +: LANE_W] = LANE_W'({n[7:0], cnt});
  end
endmodule

/* File: bench/jrx_link_config_regs_chk.sv */
`timescale 1ns/10ps
module jrx_chk
(
  // Watched ports
  input wire clk_i,
  input wire rst_n_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire hready_i,
  input wire hreadyout_o,
  input wire hresp_o,
  input wire [31:0] hrdata_o,
  input wire link_enable_o,
  input wire pclk_en_i,
  input wire buffer_release_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  wire tk = hsel_i & htrans_i[1] & hready_i;
  wire wr_ctl = tk & hwrite_i & (haddr_i == 32'h0000_0c00);
  okay_only_a: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (tk & !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read wait wrong");
  write_ready_a: assert property (tk & hwrite_i |=> hreadyout_o)
    else $error("write stalled");
  wait_once_a: assert property (!hreadyout_o |=> hreadyout_o)
    else $error("wait too long");
  fall_cause_a: assert property ($fell(hreadyout_o) |-> $past(tk & !hwrite_i))
    else $error("stray wait");
  rdata_hold_a: assert property ($changed(hrdata_o) |-> $past(!hreadyout_o))
    else $error("read data moved");
  link_cause_a: assert property ($changed(link_enable_o) |-> $past(wr_ctl, 2))
    else $error("enable moved alone");
  release_gate_a: assert property (buffer_release_o |-> $past(link_enable_o & pclk_en_i))
    else $error("release while off");
endmodule
////////////////////////////////////////////////////////////////
bind jrx_link_config_regs jrx_chk jrx_chk_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .hrdata_o(hrdata_o), .link_enable_o(link_enable_o), .pclk_en_i(pclk_en_i),
  .buffer_release_o(buffer_release_o));

/* File: bench/tb_jrx_link_config_regs.sv */
`timescale 1ns/10ps
`include "jrx_defs.vh"
module tb_jrx_link_config_regs;
  logic clk_i, rst_n_i, hsel, hwrite, hrdy, hresp, fen, len, gmf, lmf, gdly, brel;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans;
  logic [3:0] cal5, cal6, cal7, t5, t6, t7;
  logic [87:0] cfg;
  logic [7:0] cks;
  logic [255:0] lanes;
  logic [31:0] ll0, ll1;
  logic [2:0] kk;
  int num_errors = 0;
  int checks_done = 0;
  int i, n;
  logic [9:0] ix [8] = '{`JRX_IDX_TRIM5, `JRX_IDX_TRIM6, `JRX_IDX_TRIM7, `JRX_IDX_GENCTL,
    `JRX_IDX_FIXDLY, `JRX_IDX_RELPT, `JRX_IDX_XBAR01, 10'h3ff};
  logic [7:0] rv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1f, 8'h08, 8'h00};
  // Bits kept clear in the write: link enable stays off, release point is set to ten
  logic [7:0] wx [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h15, 8'h00, 8'h00};
  logic [7:0] mk [8] = '{8'h0f, 8'h0f, 8'h0f, 8'h40, 8'h1f, 8'h0a, 8'h3f, 8'h00};
  jrx_link_config_regs jrx_link_config_regs_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy),
    .hresp_o(hresp), .hrdata_o(hrdata), .cal_code5_i(cal5), .cal_code6_i(cal6),
    .cal_code7_i(cal7), .term_code5_o(t5), .term_code6_o(t6), .term_code7_o(t7),
    .cfg_octets_i(cfg), .checksum_o(cks), .link_enable_o(len), .pclk_en_i(1'b1),
    .frame_en_i(fen), .global_lmfc_i(gmf), .local_lmfc_i(lmf),
    .global_lmfc_dly_o(gdly), .buffer_release_o(brel), .serial_lanes_i(lanes),
    .logical_lane0_o(ll0), .logical_lane1_o(ll1));
  jrx_tx_model jrx_tx_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .lanes_o(lanes),
    .cfg_o(cfg), .gmf_o(gmf), .lmf_o(lmf));
  // Frame enable at half rate, in step with the model's counter bit 0
  always @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      fen <= 1'b0;
    else
      fen <= ~fen;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input [31:0] got, input [31:0] exp);
  begin
    checks_done = checks_done + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  // Ready and read data taken at the rising edge, before the slave updates
  task automatic bus(input w, input [9:0] a, input [31:0] wd, output [31:0] rd);
  begin
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a, 2'h0};
    do @(posedge clk_i); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    rd = hrdata;
  end
  endtask
  task automatic wr(input [9:0] a, input [31:0] wd);
    logic [31:0] v;
    bus(1'b1, a, wd, v);
  endtask
  task automatic rd(input [9:0] a, input [31:0] e);
    logic [31:0] v;
  begin
    bus(1'b0, a, 32'h0, v);
    chk(v, e);
  end
  endtask
  function automatic [3:0] tc(input [3:0] c, input [3:0] t);
    logic [4:0] s;
  begin
    s = t[3] ? {1'b0, c} - t[2:0] : {1'b0, c} + t[2:0];
    tc = s[4] ? (t[3] ? 4'h0 : 4'hf) : s[3:0];
  end
  endfunction
  task automatic rel_count(input int e);
  begin
    n = 0;
    repeat (128) @(negedge clk_i) n = n + (brel === 1'b1);
    chk(32'(n), 32'(e));
  end
  endtask
  task wrap_up;
  begin
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial
  begin
    {rst_n_i, hsel, hwrite, htrans, haddr, hwdata} = '0;
    cal5 = 4'h8;
    cal6 = 4'h2;
    cal7 = 4'hc;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rd(ix[i], rv[i]);
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(ix[i], ~{24'h0, wx[i]});
      rd(ix[i], mk[i]);
    end
    rd(`JRX_IDX_LATENCY, 32'h6);
    wr(`JRX_IDX_LATENCY, 32'h1f);
    rd(`JRX_IDX_LATENCY, 32'h6);
    wr(`JRX_IDX_TRIM5, 32'h3);
    wr(`JRX_IDX_TRIM6, 32'hb);
    wr(`JRX_IDX_TRIM7, 32'h7);
    repeat (3) @(negedge clk_i);
    chk(t5, tc(cal5, 4'h3));
    chk(t6, tc(cal6, 4'hb));
    chk(t7, tc(cal7, 4'h7));
    wr(`JRX_IDX_GENCTL, 32'h0);
    repeat (3) @(negedge clk_i);
    chk(cks, 8'h0c);
    wr(`JRX_IDX_GENCTL, 32'h40);
    repeat (3) @(negedge clk_i);
    chk(cks, 8'ha9);
    wr(`JRX_IDX_RELPT, 32'h4);
    rel_count(0);
    wr(`JRX_IDX_GENCTL, 32'h1);
    rd(`JRX_IDX_GENCTL, 32'h1);
    chk(len, 1'b1);
    rel_count(4);
    for (i = 0; i < 2; i = i + 1)
    begin
      d = 32'(i * 5);
      wr(`JRX_IDX_FIXDLY, d);
      do @(negedge clk_i); while (gmf !== 1'b1);
      n = 0;
      do
      begin
        @(negedge clk_i);
        n = n + 1;
      end
      while (gdly !== 1'b1 && n < 40);
      // Frame enables come every other cycle, so each delay step takes two
      chk(32'(n), (d == 32'h0) ? 32'h1 : {d[30:0], 1'b0});
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      kk = i[2:0];
      wr(`JRX_IDX_XBAR01, {26'h0, kk, ~kk});
      repeat (2) @(negedge clk_i);
      chk(ll1[31:24], {5'h0, kk});
      chk(ll0[31:24], {5'h0, ~kk});
    end
    wrap_up;
  end
endmodule
